// ---- verilog/vap_pkg.sv ----
/*
 vap_pkg: shared constants and carriers for the vibration converter pacing,
 averaging and per-channel control block.
 Assumes a single 100 MHz core clock and a plain address/strobe register port.
*/
package vap_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [7:0] VAP_LAYER_CMD_OFS = 8'h00;
   localparam logic [7:0] VAP_LAYER_STS_OFS = 8'h04;
   localparam logic [7:0] VAP_CHAN_CMD_OFS = 8'h08;
   localparam logic [7:0] VAP_CHAN_THR_OFS = 8'h0C;
   localparam logic [7:0] VAP_CHAN_STS_OFS = 8'h10;
   localparam logic [7:0] VAP_SEC_CNT_OFS = 8'h14;

   // ------------------------------------------------------------
   // layer command word fields
   // ------------------------------------------------------------
   localparam int VAP_L_SRC_LSB = 0;
   localparam int VAP_L_DIV_LSB = 5;
   localparam int VAP_L_FMT_BIT = 15;
   localparam int VAP_L_AVG_LSB = 16;
   localparam int VAP_L_SEL_SRC = 20;
   localparam int VAP_L_SEL_DIV = 21;
   localparam int VAP_L_SEL_FMT = 22;
   localparam int VAP_L_SEL_AVG = 23;
   localparam int VAP_L_SEL_FIR = 24;
   localparam int VAP_L_SEL_DEF = 25;

   // ------------------------------------------------------------
   // channel command word fields
   // ------------------------------------------------------------
   localparam int VAP_C_CHAN_LSB = 0;
   localparam int VAP_C_BIAS_BIT = 4;
   localparam int VAP_C_TEST_BIT = 5;
   localparam int VAP_C_FILT_BIT = 6;
   localparam int VAP_C_MAIN_BIT = 7;
   localparam int VAP_C_SEC_BIT = 8;
   localparam int VAP_C_SN_LSB = 9;
   localparam int VAP_C_SEL_BIAS = 24;
   localparam int VAP_C_SEL_TEST = 25;
   localparam int VAP_C_SEL_FILT = 26;
   localparam int VAP_C_SEL_MAIN = 27;
   localparam int VAP_C_SEL_SEC = 28;
   localparam int VAP_C_SEL_SN = 29;
   localparam int VAP_C_SEL_HI = 30;
   localparam int VAP_C_SEL_LO = 31;
   localparam int VAP_T_HI_LSB = 0;
   localparam int VAP_T_LO_LSB = 16;

   // ------------------------------------------------------------
   // codes and reset values
   // ------------------------------------------------------------
   localparam logic [4:0] VAP_SRC_66M = 5'h00;
   localparam logic [4:0] VAP_SRC_24M = 5'h10;
   localparam logic [4:0] VAP_SRC_SYNC2 = 5'h18;
   localparam logic [4:0] VAP_SRC_BUS0 = 5'h08;
   localparam logic [4:0] VAP_SRC_BUS3 = 5'h0B;
   localparam logic [9:0] VAP_DIV_RST = 10'h041;
   localparam logic [3:0] VAP_AVG_RST = 4'h0;
   localparam logic VAP_FMT_NORMAL = 1'b0;
   localparam logic [14:0] VAP_SECN_RST = 15'h0000;
   localparam logic [11:0] VAP_THR_RST = 12'h000;

   typedef struct packed {
      logic [4:0] src;
      logic [9:0] div;
      logic fmt_reduced;
      logic [3:0] avg;
      logic fir_follow;
   } vap_layer_s;

   typedef struct packed {
      logic bias_on;
      logic test_on;
      logic filt_on;
      logic main_on;
      logic sec_on;
      logic [14:0] secn;
      logic [11:0] thr_hi;
      logic [11:0] thr_lo;
   } vap_chan_s;

endpackage

// ---- verilog/vap_core.sv ----
/*
 vap_core: pacing clock selection and division, power-of-two averaging,
 per-channel gating, filter/test controls and secondary-converter pacing.
 Assumes source clocks arrive as one-cycle tick pulses synchronous to
 core_clk_in, and samples as valid-qualified SW-bit words per channel (24 by default).
*/
// Function
// - source codes 0,0x10,0x18,0x8-0xB select clock
// - pacing equals source divided by divider+1
// - divider up to 1023, resets to 65
// - average two-to-factor samples, factor up to 15
// - both flags set adapt default filter coefficients
// - format 0 normal, 1 reduced, default normal
// - secondary converts once per programmed main count plus one
// - secondary data transferred at secondary rate; code sends no transfer while the programmed count is 0
// - secondary off stops transfer, clears LED
// - secondary enable gates LED operation
// - main flow gate: 0 blocks, 1 passes
// - per-channel 48KHz filter on at 1
// - bias off plus test grounds input
// - only selected parameters update on write, but every non-default layer write reloads the FIR follow flag; threshold writes load both thresholds with no select
// - defaults flag restores layer, ignores others
// - layer settings shared by all channels
// - 12-bit thresholds, zero disables comparison
`timescale 1ns/1ns
module vap_core
   import vap_pkg::*;
#(
   parameter int NCH = 4,
   parameter int SW = 24
)
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // pacing sources as tick pulses
   input wire logic tick_66m_in,
   input wire logic tick_24m_in,
   input wire logic sync2_in,
   input wire logic [3:0] sync_bus_in,
   // main converter samples and secondary levels
   input wire logic [NCH-1:0] smp_valid_in,
   input wire logic [NCH*SW-1:0] smp_data_in,
   input wire logic [NCH*12-1:0] sec_level_in,
   // outputs
   output logic conv_out,
   output logic [NCH-1:0] avg_valid_out,
   output logic [NCH*SW-1:0] avg_data_out,
   output logic fmt_reduced_out,
   output logic fir_adapt_out,
   output logic [3:0] fir_avg_out,
   output logic [NCH-1:0] filt_on_out,
   output logic [NCH-1:0] bias_on_out,
   output logic [NCH-1:0] ground_out,
   output logic [NCH-1:0] sec_conv_out,
   output logic [NCH-1:0] sec_xfer_out,
   output logic [NCH-1:0] led_out
);

   if (NCH < 1 || NCH > 4 || SW < 2 || SW > 24)
   begin : g_bad_param
      $error("vap_core: unsupported channel count or sample width");
   end

   localparam int AW = SW + 15;

   // ------------------------------------------------------------
   // layer configuration
   // ------------------------------------------------------------
   vap_layer_s lay;
   logic [31:0] w;
   logic lay_wr;
   logic chan_wr;
   logic thr_wr;
   assign w = wdata_in;
   assign lay_wr = wr_in && addr_in == VAP_LAYER_CMD_OFS;
   assign chan_wr = wr_in && addr_in == VAP_CHAN_CMD_OFS;
   assign thr_wr = wr_in && addr_in == VAP_CHAN_THR_OFS;

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         lay.src <= VAP_SRC_66M;
         lay.div <= VAP_DIV_RST;
         lay.fmt_reduced <= VAP_FMT_NORMAL;
         lay.avg <= VAP_AVG_RST;
         lay.fir_follow <= 1'b0;
      end
      else if (lay_wr)
      begin
         if (w[VAP_L_SEL_DEF])
         begin
            lay.src <= VAP_SRC_66M;
            lay.div <= VAP_DIV_RST;
            lay.fmt_reduced <= VAP_FMT_NORMAL;
            lay.avg <= VAP_AVG_RST;
            lay.fir_follow <= 1'b0;
         end
         else
         begin
            if (w[VAP_L_SEL_SRC])
               lay.src <= w[VAP_L_SRC_LSB +: 5];
            if (w[VAP_L_SEL_DIV])
               lay.div <= w[VAP_L_DIV_LSB +: 10];
            if (w[VAP_L_SEL_FMT])
               lay.fmt_reduced <= w[VAP_L_FMT_BIT];
            if (w[VAP_L_SEL_AVG])
               lay.avg <= w[VAP_L_AVG_LSB +: 4];
            lay.fir_follow <= w[VAP_L_SEL_FIR];
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         fir_adapt_out <= 1'b0;
         fir_avg_out <= 4'h0;
         fmt_reduced_out <= VAP_FMT_NORMAL;
      end
      else
      begin
         fir_adapt_out <= lay_wr && !w[VAP_L_SEL_DEF] && w[VAP_L_SEL_AVG] && w[VAP_L_SEL_FIR];
         if (lay_wr && !w[VAP_L_SEL_DEF] && w[VAP_L_SEL_AVG] && w[VAP_L_SEL_FIR])
            fir_avg_out <= w[VAP_L_AVG_LSB +: 4];
         fmt_reduced_out <= lay.fmt_reduced;
      end
   end

   // ------------------------------------------------------------
   // pacing source and divider
   // ------------------------------------------------------------
   logic src_tick;
   logic [9:0] div_cnt;
   always_comb
   begin
      case (lay.src)
         VAP_SRC_66M: src_tick = tick_66m_in;
         VAP_SRC_24M: src_tick = tick_24m_in;
         VAP_SRC_SYNC2: src_tick = sync2_in;
         // unlisted codes stall pacing rather than guess a source
         default: src_tick = lay.src >= VAP_SRC_BUS0 && lay.src <= VAP_SRC_BUS3 && sync_bus_in[lay.src[1:0]];
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         div_cnt <= 10'h000;
         conv_out <= 1'b0;
      end
      else
      begin
         conv_out <= 1'b0;
         if (src_tick)
         begin
            if (div_cnt >= lay.div)
            begin
               div_cnt <= 10'h000;
               conv_out <= 1'b1;
            end
            else
               div_cnt <= div_cnt + 10'h001;
         end
      end
   end

   // ------------------------------------------------------------
   // per-channel settings
   // ------------------------------------------------------------
   vap_chan_s ch [NCH];
   logic [15:0] sec_cnt [NCH];

   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         logic [AW-1:0] acc;
         logic [15:0] n_cnt;
         logic [15:0] n_tgt;
         logic [11:0] lvl;
         logic hit;
         logic [AW-1:0] sum;
         assign n_tgt = 16'h0001 << lay.avg;
         assign lvl = sec_level_in[g*12 +: 12];
         assign sum = acc + AW'(signed'(smp_data_in[g*SW +: SW]));

         always_ff @(posedge core_clk_in or negedge rstn_in)
         begin
            if (!rstn_in)
            begin
               ch[g].bias_on <= 1'b0;
               ch[g].test_on <= 1'b0;
               ch[g].filt_on <= 1'b0;
               ch[g].main_on <= 1'b0;
               ch[g].sec_on <= 1'b0;
               ch[g].secn <= VAP_SECN_RST;
               ch[g].thr_hi <= VAP_THR_RST;
               ch[g].thr_lo <= VAP_THR_RST;
            end
            else if (chan_wr && w[VAP_C_CHAN_LSB + g])
            begin
               if (w[VAP_C_SEL_BIAS])
                  ch[g].bias_on <= w[VAP_C_BIAS_BIT];
               if (w[VAP_C_SEL_TEST])
                  ch[g].test_on <= w[VAP_C_TEST_BIT];
               if (w[VAP_C_SEL_FILT])
                  ch[g].filt_on <= w[VAP_C_FILT_BIT];
               if (w[VAP_C_SEL_MAIN])
                  ch[g].main_on <= w[VAP_C_MAIN_BIT];
               if (w[VAP_C_SEL_SEC])
                  ch[g].sec_on <= w[VAP_C_SEC_BIT];
               if (w[VAP_C_SEL_SN])
                  ch[g].secn <= w[VAP_C_SN_LSB +: 15];
            end
            else if (thr_wr && w[VAP_C_CHAN_LSB + g + 12])
            begin
               ch[g].thr_hi <= w[VAP_T_HI_LSB +: 12];
               ch[g].thr_lo <= w[VAP_T_LO_LSB +: 12];
            end
         end

         always_ff @(posedge core_clk_in or negedge rstn_in)
         begin
            if (!rstn_in)
            begin
               acc <= '0;
               n_cnt <= 16'h0000;
               avg_valid_out[g] <= 1'b0;
               avg_data_out[g*SW +: SW] <= '0;
            end
            else
            begin
               avg_valid_out[g] <= 1'b0;
               if (smp_valid_in[g] && ch[g].main_on)
               begin
                  if (n_cnt + 16'h0001 >= n_tgt)
                  begin
                     avg_data_out[g*SW +: SW] <= SW'($signed(sum) >>> lay.avg);
                     avg_valid_out[g] <= 1'b1;
                     acc <= '0;
                     n_cnt <= 16'h0000;
                  end
                  else
                  begin
                     acc <= sum;
                     n_cnt <= n_cnt + 16'h0001;
                  end
               end
            end
         end

         always_ff @(posedge core_clk_in or negedge rstn_in)
         begin
            if (!rstn_in)
            begin
               sec_cnt[g] <= 16'h0000;
               sec_conv_out[g] <= 1'b0;
               sec_xfer_out[g] <= 1'b0;
            end
            else
            begin
               sec_conv_out[g] <= 1'b0;
               sec_xfer_out[g] <= 1'b0;
               if (conv_out && ch[g].sec_on)
               begin
                  if (sec_cnt[g] >= {1'b0, ch[g].secn})
                  begin
                     sec_cnt[g] <= 16'h0000;
                     sec_conv_out[g] <= 1'b1;
                     sec_xfer_out[g] <= ch[g].secn != VAP_SECN_RST;
                  end
                  else
                     sec_cnt[g] <= sec_cnt[g] + 16'h0001;
               end
            end
         end

         assign hit = (ch[g].thr_hi != VAP_THR_RST && lvl > ch[g].thr_hi)
            || (ch[g].thr_lo != VAP_THR_RST && lvl < ch[g].thr_lo);

         always_ff @(posedge core_clk_in or negedge rstn_in)
         begin
            if (!rstn_in)
            begin
               led_out[g] <= 1'b0;
               filt_on_out[g] <= 1'b0;
               bias_on_out[g] <= 1'b0;
               ground_out[g] <= 1'b0;
            end
            else
            begin
               // LED only while enabled, regardless of transfer
               if (!ch[g].sec_on)
                  led_out[g] <= 1'b0;
               else if (sec_conv_out[g])
                  led_out[g] <= hit;
               filt_on_out[g] <= ch[g].filt_on;
               bias_on_out[g] <= ch[g].bias_on;
               ground_out[g] <= !ch[g].bias_on && ch[g].test_on;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   logic [31:0] next_rdata;
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (addr_in)
         VAP_LAYER_STS_OFS: next_rdata = {11'h000, lay.fir_follow, lay.avg, lay.fmt_reduced, lay.div, lay.src};
         VAP_CHAN_STS_OFS:
         begin
            for (int i = 0; i < NCH; i++)
            begin
               next_rdata[i*8 +: 8] = {led_out[i], ground_out[i], ch[i].sec_on, ch[i].main_on,
                  ch[i].filt_on, ch[i].test_on, ch[i].bias_on, avg_valid_out[i]};
            end
         end
         VAP_SEC_CNT_OFS: next_rdata = {16'h0000, sec_cnt[0]};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         rdata_out <= 32'h0000_0000;
      else
         rdata_out <= rd_in ? next_rdata : 32'h0000_0000;
   end

endmodule // vap_core

// ---- tb/vap_core_sva.sv ----
/*
 vap_core_sva: concurrent checks on the vap_core ports.
 Assumes one core clock domain; bound to every vap_core instance.
*/
`timescale 1ns/1ns
module vap_core_sva
   import vap_pkg::*;
#(
   parameter int NCH = 4
)
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // watched inputs
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic tick_66m_in,
   input wire logic tick_24m_in,
   input wire logic sync2_in,
   input wire logic [3:0] sync_bus_in,
   input wire logic [NCH-1:0] smp_valid_in,
   // watched outputs
   input wire logic conv_out,
   input wire logic [NCH-1:0] avg_valid_out,
   input wire logic fmt_reduced_out,
   input wire logic fir_adapt_out,
   input wire logic [3:0] fir_avg_out,
   input wire logic [NCH-1:0] filt_on_out,
   input wire logic [NCH-1:0] bias_on_out,
   input wire logic [NCH-1:0] ground_out,
   input wire logic [NCH-1:0] sec_conv_out,
   input wire logic [NCH-1:0] sec_xfer_out
);
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);

   property p_fir_adapt;
      wr_in && addr_in == VAP_LAYER_CMD_OFS && wdata_in[25:23] == 3'b011
         |=> fir_adapt_out && fir_avg_out == $past(wdata_in[19:16]);
   endproperty
   a_fir_adapt: assert property (p_fir_adapt) else $error("filter adapt pulse missing");

   property p_fir_cause;
      fir_adapt_out |-> $past(wr_in && addr_in == VAP_LAYER_CMD_OFS && wdata_in[25:23] == 3'b011);
   endproperty
   a_fir_cause: assert property (p_fir_cause) else $error("filter adapt without cause");

   property p_ground;
      (ground_out & bias_on_out) == '0;
   endproperty
   a_ground: assert property (p_ground) else $error("grounded with bias on");

   property p_xfer;
      (sec_xfer_out & ~sec_conv_out) == '0;
   endproperty
   a_xfer: assert property (p_xfer) else $error("transfer off secondary pace");

   property p_sec_conv;
      |sec_conv_out |-> $past(conv_out);
   endproperty
   a_sec_conv: assert property (p_sec_conv) else $error("secondary without main pace");

   property p_avg;
      (avg_valid_out & ~$past(smp_valid_in)) == '0;
   endproperty
   a_avg: assert property (p_avg) else $error("average without sample");

   property p_fmt;
      $changed(fmt_reduced_out) |-> $past(wr_in && addr_in == VAP_LAYER_CMD_OFS, 2);
   endproperty
   a_fmt: assert property (p_fmt) else $error("format moved without write");

   property p_filt;
      $changed(filt_on_out) |-> $past(wr_in && addr_in == VAP_CHAN_CMD_OFS, 2);
   endproperty
   a_filt: assert property (p_filt) else $error("filter moved without write");

   property p_conv;
      conv_out |-> $past(tick_66m_in || tick_24m_in || sync2_in || (|sync_bus_in));
   endproperty
   a_conv: assert property (p_conv) else $error("pace without source tick");
endmodule // vap_core_sva

bind vap_core vap_core_sva #(.NCH(NCH)) chk_u (.*);

// ---- tb/vap_sensor_model.sv ----
/*
 vap_sensor_model: behavioural sensor front end, one sample per pace.
 Assumes the bench supplies per-channel base values and secondary levels.
*/
`timescale 1ns/1ns
module vap_sensor_model
   import vap_pkg::*;
#(
   parameter int NCH = 4,
   parameter int SW = 24,
   parameter int LAT = 2
)
(
   // clock, reset and pacing
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic conv_in,
   // bench settings
   input wire logic [NCH*SW-1:0] base_in,
   input wire logic [NCH*12-1:0] level_in,
   // converter side
   output logic [NCH-1:0] smp_valid_out,
   output logic [NCH*SW-1:0] smp_data_out,
   output logic [NCH*12-1:0] sec_level_out
);
   logic [LAT:0] pipe;
   logic [1:0] step;
   assign sec_level_out = level_in;
   // data lines toggle between samples so a stale word is never mistaken for fresh
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pipe <= '0;
         step <= 2'h0;
         smp_valid_out <= '0;
         smp_data_out <= '0;
      end
      else
      begin
         pipe <= {pipe[LAT-1:0], conv_in};
         smp_valid_out <= {NCH{pipe[LAT-1]}};
         if (pipe[LAT-1])
         begin
            step <= step + 2'h1;
            for (int c = 0; c < NCH; c++)
               smp_data_out[c*SW +: SW] <= base_in[c*SW +: SW] + SW'(step);
         end
         else
            smp_data_out <= ~smp_data_out;
      end
   end
endmodule // vap_sensor_model

// ---- tb/test_vap_core.sv ----
/*
 test_vap_core: register-driven sequences against vap_core and a sensor model.
 Assumes the 100 MHz core clock and the vap_pkg register layout.
*/
`timescale 1ns/1ns
module test_vap_core
   import vap_pkg::*;
;
   logic core_clk_in, rstn_in, wr_in, rd_in, tick_66m_in, tick_24m_in, sync2_in, conv_out;
   logic fmt_reduced_out, fir_adapt_out;
   logic [7:0] addr_in;
   logic [31:0] wdata_in, rdata_out;
   logic [3:0] sync_bus_in, smp_valid_in, avg_valid_out, filt_on_out, bias_on_out, ground_out;
   logic [3:0] sec_conv_out, sec_xfer_out, led_out, fir_avg_out;
   logic [95:0] smp_data_in, avg_data_out, base;
   logic [47:0] sec_level_in, level;
   logic [23:0] last_avg [4];
   logic [4:0] codes [7] = '{5'h00, 5'h10, 5'h18, 5'h08, 5'h09, 5'h0A, 5'h0B};
   int fails = 0, checked = 0, nconv = 0, nsec = 0, nxfer = 0, n0, s0, x0;
   int navg [4] = '{default: 0};
   int a0 [4];

   vap_core dut_u (.*);
   vap_sensor_model sens_u (.core_clk_in, .rstn_in, .conv_in(conv_out), .base_in(base),
      .level_in(level), .smp_valid_out(smp_valid_in), .smp_data_out(smp_data_in),
      .sec_level_out(sec_level_in));

   initial
   begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end

   always @(posedge core_clk_in)
   begin
      nconv += (conv_out === 1'b1);
      nsec += (sec_conv_out[0] === 1'b1);
      nxfer += (sec_xfer_out[0] === 1'b1);
      for (int c = 0; c < 4; c++)
         if (avg_valid_out[c] === 1'b1)
         begin
            navg[c]++;
            last_avg[c] = avg_data_out[c*24 +: 24];
         end
   end

   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, exp);
   endtask

   task automatic lay(input logic [4:0] src, input logic [9:0] dv, input logic f, input logic [3:0] av,
      input logic [5:0] sel);
      wr(VAP_LAYER_CMD_OFS, {6'h00, sel, av, f, dv, src});
   endtask

   task automatic ch(input logic [3:0] m, input logic [4:0] v, input logic [14:0] n, input logic [5:0] sel);
      wr(VAP_CHAN_CMD_OFS, {2'h0, sel, n, v, m});
      // channel levels pass two registers, so let one more edge go by
      @(posedge core_clk_in);
      #1;
   endtask

   task automatic thr(input logic [3:0] m, input logic [11:0] hi, input logic [11:0] lo);
      wr(VAP_CHAN_THR_OFS, {4'hC, lo, m, hi});
   endtask

   // one-cycle ticks on the line named by a source code, then let results settle
   task automatic tick(input logic [4:0] code, input int n);
      repeat (n)
      begin
         @(posedge core_clk_in);
         tick_66m_in <= (code == VAP_SRC_66M);
         tick_24m_in <= (code == VAP_SRC_24M);
         sync2_in <= (code == VAP_SRC_SYNC2);
         for (int b = 0; b < 4; b++)
            sync_bus_in[b] <= (code == VAP_SRC_BUS0 + 5'(b));
         @(posedge core_clk_in);
         {tick_66m_in, tick_24m_in, sync2_in, sync_bus_in} <= '0;
      end
      repeat (8) @(posedge core_clk_in);
      #1;
   endtask

   task automatic stop_test;
      if (fails == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------
   // sequences
   // ----------------------------------------
   initial
   begin
      {wr_in, rd_in, tick_66m_in, tick_24m_in, sync2_in, sync_bus_in} = '0;
      addr_in = 8'h00;
      wdata_in = 32'h00000000;
      base = {24'hFFFFD8, 24'h00001E, 24'h000014, 24'h00000A};
      level = 48'h000000000200;
      rstn_in = 1'b0;
      repeat (16) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      rd(VAP_LAYER_STS_OFS, 32'h00000820);
      lay(5'h10, 10'h005, 1'b1, 4'h3, 6'h3F);
      rd(VAP_LAYER_STS_OFS, 32'h00000820);
      lay(5'h10, 10'h003, 1'b1, 4'h0, 6'h03);
      wr(8'h3C, 32'hFFFFFFFF);
      rd(VAP_LAYER_STS_OFS, 32'h00000070);
      rd(8'h3C, 32'h00000000);
      lay(5'h00, 10'h3FF, 1'b0, 4'h0, 6'h02);
      rd(VAP_LAYER_STS_OFS, 32'h00007FF0);
      lay(5'h00, 10'h000, 1'b1, 4'h0, 6'h04);
      @(posedge core_clk_in);
      #1;
      chk(fmt_reduced_out, 32'h00000001);
      lay(5'h00, 10'h000, 1'b0, 4'h0, 6'h04);
      @(posedge core_clk_in);
      #1;
      chk(fmt_reduced_out, 32'h00000000);
      // divider held at the floor allowed for the fast sources
      foreach (codes[i])
      begin
         lay(codes[i], VAP_DIV_RST, 1'b0, 4'h0, 6'h03);
         n0 = nconv;
         tick((codes[i] == VAP_SRC_SYNC2) ? VAP_SRC_66M : VAP_SRC_SYNC2, 3);
         tick(codes[i], 65);
         chk(nconv - n0, 32'h00000000);
         tick(codes[i], 1);
         chk(nconv - n0, 32'h00000001);
      end
      lay(VAP_SRC_SYNC2, 10'h000, 1'b0, 4'h2, 6'h1B);
      chk({fir_adapt_out, fir_avg_out}, 32'h00000012);
      ch(4'hF, 5'b01000, 15'h0000, 6'h08);
      a0 = navg;
      tick(VAP_SRC_SYNC2, 4);
      for (int c = 0; c < 4; c++)
      begin
         chk(navg[c] - a0[c], 32'h00000001);
         chk(last_avg[c], base[c*24 +: 24] + 24'h000001);
      end
      ch(4'h1, 5'b00000, 15'h0000, 6'h08);
      a0 = navg;
      tick(VAP_SRC_SYNC2, 4);
      chk(navg[0] - a0[0], 32'h00000000);
      chk(navg[1] - a0[1], 32'h00000001);
      ch(4'h2, 5'b00010, 15'h0000, 6'h03);
      chk(ground_out, 32'h00000002);
      ch(4'h8, 5'b00100, 15'h0000, 6'h04);
      chk({filt_on_out, ground_out}, 32'h00000082);
      ch(4'h2, 5'b00001, 15'h0000, 6'h01);
      chk({bias_on_out, ground_out}, 32'h00000020);
      thr(4'h1, 12'h100, 12'h000);
      ch(4'h1, 5'b10000, 15'h0002, 6'h30);
      s0 = nsec;
      x0 = nxfer;
      tick(VAP_SRC_SYNC2, 9);
      chk(nsec - s0, 32'h00000003);
      chk(nxfer - x0, 32'h00000003);
      chk(led_out[0], 32'h00000001);
      ch(4'h1, 5'b10000, 15'h0000, 6'h20);
      x0 = nxfer;
      level[11:0] <= 12'h050;
      tick(VAP_SRC_SYNC2, 2);
      chk(nxfer - x0, 32'h00000000);
      chk(led_out[0], 32'h00000000);
      level[11:0] <= 12'h200;
      thr(4'h1, 12'h000, 12'h000);
      tick(VAP_SRC_SYNC2, 2);
      chk(led_out[0], 32'h00000000);
      thr(4'h1, 12'h100, 12'h000);
      tick(VAP_SRC_SYNC2, 2);
      chk(led_out[0], 32'h00000001);
      ch(4'h1, 5'b00000, 15'h0000, 6'h10);
      tick(VAP_SRC_SYNC2, 2);
      chk(led_out[0], 32'h00000000);
      stop_test();
   end

   initial
   begin
      repeat (20000) @(posedge core_clk_in);
      fails++;
      stop_test();
   end
endmodule // test_vap_core
